/* hw/slpg_lane.sv */
// package of constants and the per-lane serializer for the lane output framer
`default_nettype none

package slpg_pkg;
	// ************************************************************
	// word format and lane framing
	// ************************************************************
	localparam int WORD_BITS      = 12;
	localparam int CHANNELS       = 8;
	localparam int PHASE_W        = 4;
	localparam logic [3:0] PHASE_LAST    = 4'hB;
	localparam logic [3:0] WCLK_HIGH_END = 4'h5;
	// ************************************************************
	// pipeline latency, in half sampling-clock cycles
	// ************************************************************
	localparam int LATENCY_HALF   = 13;
	localparam int LATENCY_CYC    = LATENCY_HALF / 2;
	// ************************************************************
	// test patterns, bit 0 is D0
	// ************************************************************
	localparam logic [11:0] DESKEW_WORD = 12'h555;
	localparam logic [11:0] SYNC_WORD   = 12'hFC0;
	localparam logic [11:0] RESET_WORD  = 12'h000;
	// ************************************************************
	// output buffer current codes
	// ************************************************************
	localparam int CUR_W = 2;
	localparam logic [1:0] CUR_RESET = 2'h1;
	// ************************************************************
	// configuration port timing, driven by the far side
	// ************************************************************
	localparam int CFG_SCLK_PERIOD_NS = 50;
	localparam int CFG_SCLK_PHASE_NS  = 20;
	localparam int CFG_CS_SETUP_NS    = 8;
	localparam int CFG_CS_HOLD_NS     = 8;

	typedef enum logic [1:0] {
		SLPG_MODE_NORMAL,
		SLPG_MODE_DESKEW,
		SLPG_MODE_SYNC,
		SLPG_MODE_CUSTOM
	} slpg_mode_e;
endpackage

// ************************************************************
// one data lane: loads a word, shifts bit 0 out first
// ************************************************************
module slpg_lane #(
	parameter int WIDTH = 12
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] word,
	output var  logic             bit_out
);
	logic [WIDTH-1:0] sh_r;
	logic [WIDTH-1:0] sh_nxt;
	logic             bit_nxt;

	assign sh_nxt  = load ? {1'b0, word[WIDTH-1:1]} : {1'b0, sh_r[WIDTH-1:1]};
	assign bit_nxt = load ? word[0] : sh_r[0];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sh_r    <= '0;
			bit_out <= 1'b0;
		end else begin
			sh_r    <= sh_nxt;
			bit_out <= bit_nxt;
		end
	end
endmodule

`default_nettype wire

/* hw/slpg_top.sv */
// serial lane output framer: pattern select, latency pipe, crossing, serializers
`default_nettype none

module slpg_top
	import slpg_pkg::*;
#(
	parameter int NCH   = slpg_pkg::CHANNELS,
	parameter int WBITS = slpg_pkg::WORD_BITS,
	parameter int LAT   = slpg_pkg::LATENCY_CYC
) (
	input  wire logic                       ref_clk,
	input  wire logic                       resetn,
	input  wire logic                       ser_clk,
	input  wire logic [NCH*WBITS-1:0]       sample_words,
	input  wire slpg_pkg::slpg_mode_e       test_mode,
	input  wire logic                       msb_first,
	input  wire logic [3:0]                 custom_nib4,
	input  wire logic [3:0]                 custom_nib5,
	input  wire logic [3:0]                 custom_nib6,
	input  wire logic [slpg_pkg::CUR_W-1:0] current_code,
	input  wire logic                       clk_current_double,
	output var  logic [NCH-1:0]             lane_data_out,
	output var  logic                       bit_clock_out,
	output var  logic                       word_clock_out,
	output var  logic [slpg_pkg::CUR_W-1:0] data_current_out,
	output var  logic [slpg_pkg::CUR_W-1:0] clk_current_out,
	output var  logic                       clk_current_x2_out
);
	import slpg_pkg::*;

	// ************************************************************
	// elaboration checks
	// ************************************************************
	generate
		if (WBITS != WORD_BITS) begin : g_bad_width
			$error("slpg_top: serializer framing supports twelve-bit words only");
		end
		if (LAT < 1 || NCH < 1) begin : g_bad_lat
			$error("slpg_top: latency and channel count must be at least one");
		end
	endgenerate

	// ************************************************************
	// buffer current settings
	// ************************************************************
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			data_current_out   <= CUR_RESET;
			clk_current_out    <= CUR_RESET;
			clk_current_x2_out <= 1'b0;
		end else begin
			data_current_out   <= current_code;
			clk_current_out    <= current_code;
			clk_current_x2_out <= clk_current_double;
		end
	end

	// ************************************************************
	// word source per channel: converter data or a pattern
	// ************************************************************
	logic [WBITS-1:0] custom_word;
	logic [WBITS-1:0] pat_word;
	logic [NCH*WBITS-1:0] sel_words;
	logic [NCH*WBITS-1:0] ord_words;

	assign custom_word = {custom_nib6, custom_nib5, custom_nib4};
	assign pat_word = (test_mode == SLPG_MODE_DESKEW) ? DESKEW_WORD :
	                  (test_mode == SLPG_MODE_SYNC)   ? SYNC_WORD :
	                  custom_word;

	genvar gc;
	genvar gb;
	generate
		for (gc = 0; gc < NCH; gc++) begin : g_src
			assign sel_words[gc*WBITS +: WBITS] = (test_mode == SLPG_MODE_NORMAL) ?
				sample_words[gc*WBITS +: WBITS] : pat_word;
			// msb-first option is a bit reversal, the lanes always shift bit 0 first
			for (gb = 0; gb < WBITS; gb++) begin : g_ord
				assign ord_words[gc*WBITS + gb] = msb_first ?
					sel_words[gc*WBITS + WBITS-1-gb] : sel_words[gc*WBITS + gb];
			end
		end
	endgenerate

	// ************************************************************
	// latency pipe, whole sampling cycles; the final half cycle
	// comes from the serializer starting on the next word boundary
	// ************************************************************
	logic [NCH*WBITS-1:0] pipe_r [LAT];

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < LAT; i++) begin
				pipe_r[i] <= '0;
			end
		end else begin
			pipe_r[0] <= ord_words;
			for (int i = 1; i < LAT; i++) begin
				pipe_r[i] <= pipe_r[i-1];
			end
		end
	end

	// ************************************************************
	// word crossing: toggle handshake, payload held until acknowledged
	// ************************************************************
	logic [NCH*WBITS-1:0] xfer_r;
	logic                 req_r;
	logic                 ack_s1_r;
	logic                 ack_s2_r;
	logic                 ack_r;
	logic                 xfer_free;

	assign xfer_free = (req_r == ack_s2_r);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			xfer_r   <= '0;
			req_r    <= 1'b0;
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
		end else begin
			ack_s1_r <= ack_r;
			ack_s2_r <= ack_s1_r;
			if (xfer_free) begin
				xfer_r <= pipe_r[LAT-1];
				req_r  <= ~req_r;
			end
		end
	end

	// ************************************************************
	// serial clock domain: reset release synchroniser
	// ************************************************************
	logic srst_s1_r;
	logic srstn_r;

	always_ff @(posedge ser_clk or negedge resetn) begin
		if (!resetn) begin
			srst_s1_r <= 1'b0;
			srstn_r   <= 1'b0;
		end else begin
			srst_s1_r <= 1'b1;
			srstn_r   <= srst_s1_r;
		end
	end

	// ************************************************************
	// serial clock domain: request capture and word phase
	// ************************************************************
	logic                 req_s1_r;
	logic                 req_s2_r;
	logic [NCH*WBITS-1:0] held_r;
	logic [PHASE_W-1:0]   phase_r;
	logic [PHASE_W-1:0]   phase_nxt;
	logic                 word_load;
	logic                 wclk_nxt;

	// one ser_clk cycle is one bit-clock edge, so twelve cycles make a word
	assign word_load = (phase_r == PHASE_LAST);
	assign phase_nxt = word_load ? '0 : phase_r + 4'h1;
	assign wclk_nxt  = (phase_nxt <= WCLK_HIGH_END);

	always_ff @(posedge ser_clk or negedge srstn_r) begin
		if (!srstn_r) begin
			req_s1_r <= 1'b0;
			req_s2_r <= 1'b0;
			ack_r    <= 1'b0;
			held_r   <= '0;
		end else begin
			req_s1_r <= req_r;
			req_s2_r <= req_s1_r;
			// a stale word simply repeats if no new one has crossed yet
			if (req_s2_r != ack_r) begin
				held_r <= xfer_r;
				ack_r  <= req_s2_r;
			end
		end
	end

	always_ff @(posedge ser_clk or negedge srstn_r) begin
		if (!srstn_r) begin
			phase_r        <= PHASE_LAST;
			bit_clock_out  <= 1'b0;
			word_clock_out <= 1'b0;
		end else begin
			phase_r        <= phase_nxt;
			bit_clock_out  <= word_load ? 1'b1 : ~bit_clock_out;
			word_clock_out <= wclk_nxt;
		end
	end

	// ************************************************************
	// lane serializers, loaded on the word boundary with the word clock
	// ************************************************************
	generate
		for (gc = 0; gc < NCH; gc++) begin : g_lane
			slpg_lane #(
				.WIDTH (WBITS)
			) u_lane (
				.clk     (ser_clk),
				.rstn    (srstn_r),
				.load    (word_load),
				.word    (held_r[gc*WBITS +: WBITS]),
				.bit_out (lane_data_out[gc])
			);
		end
	endgenerate

endmodule

`default_nettype wire

/* sim/slpg_rx_model.sv */
// receiver model: rebuilds lane words from the word clock framing
`default_nettype none
module slpg_rx_model (
	input  wire logic        ser_clk,
	input  wire logic [7:0]  lanes,
	input  wire logic        wclk,
	output var  logic [95:0] rx_words
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [95:0] acc = '0;
	logic [3:0]  k = 4'hC;
	logic        wclk_d = 1'h1;
	// bit k arrives k cycles after the word clock rises
	always @(posedge ser_clk) begin
		if (wclk && !wclk_d) k = 4'h0;
		if (k < 4'hC) begin
			for (int c = 0; c < 8; c++) acc[c*12 + k] = lanes[c];
			if (k == 4'hB) rx_words <= acc;
			k = k + 4'h1;
		end
		wclk_d = wclk;
	end
endmodule
`default_nettype wire

/* sim/slpg_top_asserts.sv */
// port assertions for the lane output framer
`default_nettype none
module slpg_top_asserts
	import slpg_pkg::*;
(
	input wire logic             ref_clk,
	input wire logic             resetn,
	input wire logic             ser_clk,
	input wire logic [CUR_W-1:0] current_code,
	input wire logic             clk_current_double,
	input wire logic             bit_clock_out,
	input wire logic             word_clock_out,
	input wire logic [CUR_W-1:0] data_current_out,
	input wire logic [CUR_W-1:0] clk_current_out,
	input wire logic             clk_current_x2_out
);
	timeunit 1ns;
	timeprecision 1ps;
	property p_wclk; @(posedge ser_clk) disable iff (!resetn) $rose(word_clock_out) |->
		word_clock_out[*6] ##1 !word_clock_out[*6] ##1 word_clock_out; endproperty
	a_wclk: assert property (p_wclk) else $error("word clock shape");
	property p_period; @(posedge ser_clk) disable iff (!resetn)
		$rose(word_clock_out) |-> ##12 $rose(word_clock_out); endproperty
	a_period: assert property (p_period) else $error("word period");
	property p_brise; @(posedge ser_clk) disable iff (!resetn)
		$rose(word_clock_out) |-> $rose(bit_clock_out); endproperty
	a_brise: assert property (p_brise) else $error("bit clock at word start");
	property p_bseq; @(posedge ser_clk) disable iff (!resetn) $rose(word_clock_out) |->
		##1 !bit_clock_out ##1 bit_clock_out ##1 !bit_clock_out; endproperty
	a_bseq: assert property (p_bseq) else $error("bit clock toggle");
	property p_bchg; @(posedge ser_clk) disable iff (!resetn)
		$changed(word_clock_out) |-> $changed(bit_clock_out); endproperty
	a_bchg: assert property (p_bchg) else $error("clock edges apart");
	property p_dcur; @(posedge ref_clk) disable iff (!resetn)
		$past(resetn) |-> data_current_out == $past(current_code); endproperty
	a_dcur: assert property (p_dcur) else $error("data current");
	property p_ccur; @(posedge ref_clk) disable iff (!resetn)
		$past(resetn) |-> clk_current_out == $past(current_code); endproperty
	a_ccur: assert property (p_ccur) else $error("clock current");
	property p_x2; @(posedge ref_clk) disable iff (!resetn)
		$past(resetn) |-> clk_current_x2_out == $past(clk_current_double); endproperty
	a_x2: assert property (p_x2) else $error("clock doubling");
endmodule
bind slpg_top slpg_top_asserts u_chk (.ref_clk, .resetn, .ser_clk, .current_code,
	.clk_current_double, .bit_clock_out, .word_clock_out, .data_current_out,
	.clk_current_out, .clk_current_x2_out);
`default_nettype wire

/* sim/slpg_top_tb_top.sv */
// testbench for the lane output framer
`default_nettype none
module slpg_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import slpg_pkg::*;
	typedef struct {slpg_mode_e m; logic msb; logic [11:0] w, nib, exp; logic [1:0] cur;
		logic dbl;} slpg_row_s;
	slpg_row_s rows [6] = '{
		'{SLPG_MODE_NORMAL, 1'h0, 12'h9A3, 12'h000, 12'h9A3, 2'h0, 1'h0},
		'{SLPG_MODE_NORMAL, 1'h1, 12'h9A3, 12'h000, 12'hC59, 2'h3, 1'h1},
		'{SLPG_MODE_DESKEW, 1'h0, 12'h9A3, 12'h000, 12'h555, 2'h2, 1'h0},
		'{SLPG_MODE_SYNC, 1'h0, 12'h9A3, 12'h000, 12'hFC0, 2'h1, 1'h1},
		'{SLPG_MODE_CUSTOM, 1'h0, 12'h9A3, 12'h6B2, 12'h6B2, 2'h0, 1'h0},
		'{SLPG_MODE_CUSTOM, 1'h1, 12'h9A3, 12'h6B2, 12'h4D6, 2'h3, 1'h1}};
	logic ref_clk = 0, ser_clk = 0, resetn = 0, msb_first = 0, clk_current_double = 0;
	logic [95:0] sample_words = '0, rx_words, exp_all;
	slpg_mode_e test_mode = SLPG_MODE_NORMAL;
	logic [3:0] custom_nib4 = '0, custom_nib5 = '0, custom_nib6 = '0;
	logic [1:0] current_code = '0, data_current_out, clk_current_out;
	logic [7:0] lane_data_out;
	logic bit_clock_out, word_clock_out, clk_current_x2_out;
	int miscompares = 0, tests_run = 0, i;
	// capture edge, 6.5 sample cycles, then twelve link bits at 1.5 ref cycles each
	localparam int LAT_MIN = 1 + (LATENCY_HALF + WORD_BITS * 3) / 2;
	// frame length is not fixed at this level; plain default
	localparam int CFG_FRAME_BITS = 16;
	logic cfg_cs_n = 1'h1, cfg_sclk = 1'h0;
	always #10 ref_clk = ~ref_clk;
	initial begin
		#7;
		forever #15 ser_clk = ~ser_clk;
	end
	slpg_top DUT (.ref_clk, .resetn, .ser_clk, .sample_words, .test_mode, .msb_first,
		.custom_nib4, .custom_nib5, .custom_nib6, .current_code, .clk_current_double,
		.lane_data_out, .bit_clock_out, .word_clock_out, .data_current_out,
		.clk_current_out, .clk_current_x2_out);
	slpg_rx_model RX (.ser_clk, .lanes(lane_data_out), .wclk(word_clock_out), .rx_words);
	// palindromic per-channel offset, unchanged by bit reversal
	function automatic logic [11:0] pal(input int c);
		return {c[2], c[1], c[0], 6'h00, c[0], c[1], c[2]};
	endfunction
	task automatic chk(input string what, input logic [95:0] e, input logic [95:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	// far-side configuration frame; the plain ports take its contents once it closes
	task automatic cfg_frame();
		cfg_cs_n = 1'h0;
		#(CFG_CS_SETUP_NS);
		repeat (CFG_FRAME_BITS) begin
			cfg_sclk = 1'h1;
			#(CFG_SCLK_PERIOD_NS - CFG_SCLK_PHASE_NS);
			cfg_sclk = 1'h0;
			#(CFG_SCLK_PHASE_NS);
		end
		cfg_cs_n = 1'h1;
	endtask
	task automatic give_verdict();
		if (miscompares == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#50us;
		miscompares++;
		give_verdict();
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		resetn <= 1;
		foreach (rows[r]) begin
			cfg_frame();
			@(posedge ref_clk);
			test_mode <= rows[r].m;
			msb_first <= rows[r].msb;
			{custom_nib6, custom_nib5, custom_nib4} <= rows[r].nib;
			current_code <= rows[r].cur;
			clk_current_double <= rows[r].dbl;
			for (int c = 0; c < 8; c++) begin
				sample_words[c*12 +: 12] <= rows[r].w ^ pal(c);
				exp_all[c*12 +: 12] = rows[r].exp
					^ (rows[r].m == SLPG_MODE_NORMAL ? pal(c) : 12'h000);
			end
			for (i = 0; i < 120 && rx_words !== exp_all; i++) @(posedge ref_clk);
			chk("lane words", exp_all, rx_words);
			chk("currents", 96'({rows[r].cur, rows[r].cur, rows[r].dbl}),
				96'({data_current_out, clk_current_out, clk_current_x2_out}));
		end
		// new word must not show before the pipeline has run
		@(posedge ref_clk);
		msb_first <= 0;
		test_mode <= SLPG_MODE_SYNC;
		for (i = 0; i < 120 && rx_words[11:0] !== 12'hFC0; i++) @(posedge ref_clk);
		chk("latency", 96'h1, 96'(i > LAT_MIN && i < 120));
		resetn <= 0;
		repeat (3) @(posedge ref_clk);
		chk("reset outputs", 96'h00A, 96'({lane_data_out, bit_clock_out, word_clock_out,
			data_current_out, clk_current_out, clk_current_x2_out}));
		resetn <= 1;
		repeat (16) @(posedge ref_clk);
		give_verdict();
	end
endmodule
`default_nettype wire
